//--- verilog/sbc_ctrl.sv
// Serial bus control register, trigger and condition flag logic
// What this block does
// - Control register resets to zero, bit writable
// - Release trigger sets out latch, self-clears
// - Command trigger clears out latch, self-clears
// - Release flag set on release condition
// - Command flag set on command, cleared
// - Ack trigger emits ack at next fall
// - Ack trigger cleared on transfer start, disable
// - Detect flags are read-only to software
// - Trigger bits always read back zero
// - Auto-enable low: no automatic acknowledge
// - Auto-enable early: ack on ninth falling edge
// - Auto-enable late: ack next fall, stays set
// - Release is data rising while clock high
// - Command is data falling while clock high
// - Channel enable bit stops or runs channel
`timescale 1ns/1ps
`include "sbc_params.svh"
module sbc_ctrl (
  input  wire logic              ref_clk,  // 20 MHz system clock
  input  wire logic              resetn,   // Synchronous reset, active low
  input  wire sbc_pkg::sbc_bus_req_t bus,  // Register access request
  output logic [7:0]             rdata,    // Read data, cycle after read
  input  wire logic              sck_in,   // Serial clock pin level
  input  wire logic              sda_in,   // Bus data line level
  output logic                   sda_out,  // Bus data drive value (low)
  output logic                   sda_oe,   // High while pulling line low
  output logic                   irq       // Level interrupt
);
  import sbc_pkg::*;
  // Register map as software sees it:
  //   mode register: bit 7 runs the channel, other bits stored only
  //   control register: triggers, detect flags, acknowledge enables
  //   status and mask: release, command, byte done, acknowledge seen
  //   slave address, and the transfer register that starts a byte
  // Limitation: pin edges reach the logic three cycles late, so the
  // serial clock must stay far slower than a quarter of this clock.

  // Registers and pulses of the block
  logic [7:0] ctrl;       // Control register storage
  logic [7:0] mode0;      // Mode register, bit 7 channel enable
  logic [7:0] slv_addr;   // Slave address for comparison
  logic [7:0] shreg;      // Receive shift register
  logic [3:0] clk_cnt;    // Serial clock fall count in transfer
  logic       out_latch;  // Serial output latch
  logic       ack_drive;  // Acknowledge low pulse in progress
  logic       ack_pend;   // Acknowledge waits for next falling edge
  logic       xfer_done;  // Byte transfer finished
  logic       addr_phase; // Next byte is an address
  logic [3:0] irq_stat;   // Sticky events
  logic [3:0] irq_mask;   // Mask, one enables
  logic       irq_r;      // Registered interrupt
  sbc_state_t state;      // Transfer sequencer
  logic       sck_q;      // Synchronised clock
  logic       sck_rise;   // Clock rise pulse
  logic       sck_fall;   // Clock fall pulse
  logic       sda_q;      // Synchronised data
  logic       sda_rise;   // Data rise pulse
  logic       sda_fall;   // Data fall pulse
  logic       ch_en;      // Channel enable
  logic       wr_ctrl;    // Write to control register
  logic       xfer_start; // Transfer start instruction
  logic       rel_seen;   // Release condition
  logic       cmd_seen;   // Command condition
  logic       addr_miss;  // Address byte did not match
  logic       ack_fire;   // Start acknowledge on this fall
  logic       ack_seen;   // Acknowledge sampled on rise
  logic [3:0] ev;         // Events for status register
  logic       next_ack_drive; // Acknowledge drive one cycle ahead

  // Both pins come from outside; pass two flip-flops first
  // Both rest high, so the edge registers start high as well
  // Clock edges and data edges share the same three-cycle delay
  sbc_sync u_sync_sck (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     (sck_in),
    .q       (sck_q),
    .rise    (sck_rise),
    .fall    (sck_fall)
  );
  sbc_sync u_sync_sda (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     (sda_in),
    .q       (sda_q),
    .rise    (sda_rise),
    .fall    (sda_fall)
  );

  // Decode strobes and conditions
  // Channel enable gates every trigger, flag and pin action
  assign ch_en      = mode0[`SBC_BIT_CHEN];
  assign wr_ctrl    = bus.wr && (bus.addr == `SBC_OFF_CTRL);
  // A write to the transfer register starts a byte
  assign xfer_start = ch_en && bus.wr && (bus.addr == `SBC_OFF_XFER);
  // Data edges count as conditions only while the clock is high
  assign rel_seen   = ch_en && sck_q && sda_rise;
  assign cmd_seen   = ch_en && sck_q && sda_fall;
  // Address byte is judged at its last falling clock edge
  assign addr_miss  = addr_phase && (state == SBC_SHIFT) && sck_fall &&
                      (clk_cnt == `SBC_BITS_PER_BYTE - 4'd1) &&
                      ({shreg[6:0], sda_q} != slv_addr);
  // Line held low at a rise after the byte means acknowledged
  assign ack_seen   = xfer_done && sck_rise && !sda_q;
  // Manual trigger or late auto-enable waits for the next fall;
  // auto mode fires on the ninth fall only while the slot is open
  assign ack_fire   = sck_fall && (ack_pend ||
                      (ctrl[`SBC_BIT_ACK_AUTO_ENABLE] && state == SBC_ACK &&
                       clk_cnt == `SBC_ACK_CLK - 4'd1));
  // Status events in mask order: ack seen, byte done, command, release
  assign ev = {ack_seen, xfer_done & ~ack_drive & sck_fall,
               cmd_seen, rel_seen};

  // Acknowledge drive one cycle ahead, so the pin follows without delay.
  // Hazard: driving the pin from the registered copy moves the line
  // close to the next rising clock edge; both synchronisers could then
  // change in one cycle and a false release or command would be seen.
  assign next_ack_drive = ack_fire || (ack_drive && !sck_fall);

  // Mode, slave address, interrupt mask registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      // Channel starts stopped
      mode0    <= 8'h00;
      slv_addr <= 8'h00;
      irq_mask <= 4'h0;
    end else if (bus.wr) begin
      // Clearing bit 7 stops the channel and clears its flags
      if (bus.addr == `SBC_OFF_MODE0)
        mode0 <= bus.wdata;
      if (bus.addr == `SBC_OFF_SLV_ADDR)
        slv_addr <= bus.wdata;
      // Four events, so the upper mask bits are dropped
      if (bus.addr == `SBC_OFF_IRQ_MASK)
        irq_mask <= bus.wdata[3:0];
    end
  end

  // Control register: triggers, detect flags, enables
  // Bit map: 7 busy enable, 6 ack detect, 5 ack auto, 4 ack trigger,
  // 3 command detect, 2 release detect, 1 command trigger, 0 release
  // trigger. Flags 2, 3 and 6 belong to hardware; writes pass them by.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl <= `SBC_CTRL_RST;
    end else begin
      // Software writes only the writable bits; flags kept
      if (wr_ctrl) begin
        ctrl[`SBC_BIT_SYNC_BUSY_ENABLE] <= bus.wdata[`SBC_BIT_SYNC_BUSY_ENABLE];
        ctrl[`SBC_BIT_ACK_AUTO_ENABLE] <= bus.wdata[`SBC_BIT_ACK_AUTO_ENABLE];
        ctrl[`SBC_BIT_ACK_TRIGGER] <= bus.wdata[`SBC_BIT_ACK_TRIGGER];
        ctrl[`SBC_BIT_COMMAND_TRIGGER] <= bus.wdata[`SBC_BIT_COMMAND_TRIGGER];
        ctrl[`SBC_BIT_BUS_RELEASE_TRIGGER] <= bus.wdata[`SBC_BIT_BUS_RELEASE_TRIGGER];
      end
      // Release and command triggers act one cycle after the write, then clear; ack trigger clears on ack fire or transfer start
      if (ctrl[`SBC_BIT_BUS_RELEASE_TRIGGER])
        ctrl[`SBC_BIT_BUS_RELEASE_TRIGGER] <= 1'b0;
      if (ctrl[`SBC_BIT_COMMAND_TRIGGER])
        ctrl[`SBC_BIT_COMMAND_TRIGGER] <= 1'b0;
      if (ack_fire || xfer_start)
        ctrl[`SBC_BIT_ACK_TRIGGER] <= 1'b0;
      // Release flag: set beats its clears
      // so an edge in the same cycle as a clear is never lost
      if (xfer_start || addr_miss)
        ctrl[`SBC_BIT_BUS_RELEASE_DETECT] <= 1'b0;
      if (rel_seen)
        ctrl[`SBC_BIT_BUS_RELEASE_DETECT] <= 1'b1;
      // Command flag: release also clears it
      if (xfer_start || rel_seen)
        ctrl[`SBC_BIT_COMMAND_DETECT] <= 1'b0;
      if (cmd_seen)
        ctrl[`SBC_BIT_COMMAND_DETECT] <= 1'b1;
      // Acknowledge detect
      if (xfer_start)
        ctrl[`SBC_BIT_ACK_DETECT] <= 1'b0;
      if (ack_seen)
        ctrl[`SBC_BIT_ACK_DETECT] <= 1'b1;
      // Disabled channel holds triggers and flags at zero
      // Placed last so that disable beats every set and write
      if (!ch_en) begin
        ctrl[`SBC_BIT_BUS_RELEASE_TRIGGER] <= 1'b0;
        ctrl[`SBC_BIT_COMMAND_TRIGGER] <= 1'b0;
        ctrl[`SBC_BIT_ACK_TRIGGER] <= 1'b0;
        ctrl[`SBC_BIT_BUS_RELEASE_DETECT] <= 1'b0;
        ctrl[`SBC_BIT_COMMAND_DETECT] <= 1'b0;
        ctrl[`SBC_BIT_ACK_DETECT] <= 1'b0;
      end
    end
  end

  // Serial output latch, driven by the triggers
  // Resets high so the line stays released until a command
  // A transfer start releases the line too, so incoming data is seen
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      out_latch <= 1'b1;
    end else if (ctrl[`SBC_BIT_BUS_RELEASE_TRIGGER]) begin
      out_latch <= 1'b1;
    end else if (ctrl[`SBC_BIT_COMMAND_TRIGGER]) begin
      out_latch <= 1'b0;
    end else if (xfer_start) begin
      out_latch <= 1'b1; // Release line so data can shift in
    end
  end

  // Transfer sequencer: eight data clocks then the ack clock
  // Falls are counted from the first one after the start; the count
  // stops at nine, where the acknowledge slot ends
  // Trade-off: the counter waits for synchronised edges, so no second
  // clock domain is needed at the cost of a slow serial clock
  always_ff @(posedge ref_clk) begin
    if (!resetn || !ch_en) begin
      state      <= SBC_IDLE;
      clk_cnt    <= 4'd0;
      shreg      <= 8'h00;
      xfer_done  <= 1'b0;
      addr_phase <= 1'b0;
    end else begin
      if (cmd_seen)
        addr_phase <= ctrl[`SBC_BIT_BUS_RELEASE_DETECT];
      if (xfer_start) begin
        state     <= SBC_SHIFT;
        clk_cnt   <= 4'd0;
        xfer_done <= 1'b0;
        shreg     <= bus.wdata;
      end else begin
        unique case (state)
          SBC_IDLE: begin
            // Wait for a transfer start
          end
          SBC_SHIFT: begin
            // Sample data on rising clock, count falls
            if (sck_rise)
              shreg <= {shreg[6:0], sda_q};
            if (sck_fall) begin
              clk_cnt <= clk_cnt + 4'd1;
              // Eighth fall ends the data and opens the acknowledge slot
              if (clk_cnt == `SBC_BITS_PER_BYTE - 4'd1) begin
                state      <= SBC_ACK;
                xfer_done  <= 1'b1;
                addr_phase <= 1'b0;
              end
            end
          end
          SBC_ACK: begin
            // Ninth fall closes the acknowledge slot
            if (sck_fall) begin
              clk_cnt <= clk_cnt + 4'd1;
              if (clk_cnt == `SBC_ACK_CLK - 4'd1)
                state <= SBC_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Acknowledge pulse: low for one serial clock from a fall
  // The pin itself follows next_ack_drive, one cycle earlier
  always_ff @(posedge ref_clk) begin
    if (!resetn || !ch_en) begin
      ack_drive <= 1'b0;
      ack_pend  <= 1'b0;
    end else begin
      // Late auto-enable, or a manual trigger, arms the next fall
      // A late auto-enable acts once; the enable bit itself stays set
      if ((wr_ctrl && bus.wdata[`SBC_BIT_ACK_AUTO_ENABLE] &&
           !ctrl[`SBC_BIT_ACK_AUTO_ENABLE] && xfer_done && state == SBC_IDLE) ||
          (ctrl[`SBC_BIT_ACK_TRIGGER] && !ack_pend))
        ack_pend <= 1'b1;
      if (ack_fire) begin
        ack_drive <= 1'b1;
        ack_pend  <= 1'b0;
      end else if (ack_drive && sck_fall) begin
        ack_drive <= 1'b0;
      end
      if (xfer_start)
        ack_pend <= 1'b0;
    end
  end

  // Open-drain pin: enable only while pulling low
  // The drive value is always low; the pull-up makes the high level
  // Registered so the pin never glitches on a decode
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      // Pull low for a latch at zero or an acknowledge in progress
      sda_oe  <= ch_en && (!out_latch || next_ack_drive);
    end
  end

  // Sticky status; set wins over write-one-to-clear
  // Writing ones clears; an event in the same cycle still sets
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_stat <= 4'h0;
    end else begin
      if (bus.wr && bus.addr == `SBC_OFF_IRQ_STAT)
        irq_stat <= (irq_stat & ~bus.wdata[3:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
    end
  end

  // Interrupt level from a flip-flop
  // One cycle behind the status, which software never notices
  always_ff @(posedge ref_clk) begin
    if (!resetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_stat & irq_mask);
  end
  // Port copy of the registered level
  assign irq = irq_r;

  // Read port; triggers read as zero, unmapped reads zero
  // Data stand for one cycle only, then return to zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `SBC_OFF_CTRL:     rdata <= ctrl & 8'hec;
        `SBC_OFF_MODE0:    rdata <= mode0;
        `SBC_OFF_SLV_ADDR: rdata <= slv_addr;
        `SBC_OFF_IRQ_STAT: rdata <= {4'h0, irq_stat};
        `SBC_OFF_IRQ_MASK: rdata <= {4'h0, irq_mask};
        `SBC_OFF_XFER:     rdata <= shreg;
        // Unmapped addresses read as zero
        default:           rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

//--- verilog/sbc_params.svh
// Constants of the serial bus control flag block
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH
`define SBC_OFF_CTRL     16'hff61
`define SBC_OFF_MODE0    16'hff60
`define SBC_OFF_IRQ_STAT 16'hff62
`define SBC_OFF_IRQ_MASK 16'hff63
`define SBC_OFF_SLV_ADDR 16'hff64
`define SBC_OFF_XFER     16'hff65
`define SBC_CTRL_RST     8'h00
`define SBC_BIT_BUS_RELEASE_TRIGGER     0
`define SBC_BIT_COMMAND_TRIGGER     1
`define SBC_BIT_BUS_RELEASE_DETECT     2
`define SBC_BIT_COMMAND_DETECT     3
`define SBC_BIT_ACK_TRIGGER     4
`define SBC_BIT_ACK_AUTO_ENABLE     5
`define SBC_BIT_ACK_DETECT     6
`define SBC_BIT_SYNC_BUSY_ENABLE     7
`define SBC_BIT_CHEN     7
`define SBC_ACK_CLK      4'd9
`define SBC_BITS_PER_BYTE 4'd8
`endif

//--- verilog/sbc_pkg.sv
// Types shared by the serial bus control flag block
package sbc_pkg;
  typedef struct packed {
    logic [15:0] addr;  // Register address
    logic [7:0]  wdata; // Write data
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
  } sbc_bus_req_t;
  typedef enum logic [1:0] {
    SBC_IDLE = 2'b00,
    SBC_SHIFT = 2'b01,
    SBC_ACK = 2'b11
  } sbc_state_t;
endpackage

//--- verilog/sbc_sync.sv
// Two flip-flop synchroniser with edge outputs
`timescale 1ns/1ps
module sbc_sync (
  input  wire logic ref_clk, // System clock
  input  wire logic resetn,  // Synchronous reset, active low
  input  wire logic din,     // Asynchronous input
  output logic      q,       // Synchronised level
  output logic      rise,    // One-cycle pulse on rising edge
  output logic      fall     // One-cycle pulse on falling edge
);
  logic meta; // First stage, read only by the second
  logic prev; // Delayed synchronised level
  // Idle bus lines float high, so reset to one
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta <= 1'b1;
      q    <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= din;
      q    <= meta;
      prev <= q;
    end
  end
  assign rise = q & ~prev;
  assign fall = ~q & prev;
endmodule

//--- dv/sbc_checker.sv
// Port-level checks of the serial bus control block
`timescale 1ns/1ps
`include "sbc_params.svh"
module sbc_checker (
  input wire logic                  ref_clk, // Clock
  input wire logic                  resetn,  // Reset, active low
  input wire sbc_pkg::sbc_bus_req_t bus,     // Register request
  input wire logic [7:0]            rdata,   // Read data
  input wire logic                  sck_in,  // Serial clock
  input wire logic                  sda_in,  // Data line
  input wire logic                  sda_out, // Drive value
  input wire logic                  sda_oe,  // Drive enable
  input wire logic                  irq      // Interrupt
);
  import sbc_pkg::*;
  logic       chen; // Channel enable as last written
  logic [7:0] mask; // Interrupt mask as last written
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Shadow of the enable bit, so triggers can be judged
  always_ff @(posedge ref_clk) begin
    if (!resetn) chen <= 1'b0;
    else if (bus.wr && bus.addr == `SBC_OFF_MODE0) chen <= bus.wdata[7];
  end
  // Shadow of the mask register
  always_ff @(posedge ref_clk) begin
    if (!resetn) mask <= 8'h00;
    else if (bus.wr && bus.addr == `SBC_OFF_IRQ_MASK) mask <= bus.wdata;
  end
  // Trigger write with ack bits quiet, so the line is ours alone
  sequence s_ctl(logic [7:0] v);
    bus.wr && bus.addr == `SBC_OFF_CTRL && (bus.wdata & 8'h33) == v;
  endsequence
  sequence s_rd_ctl;
    bus.rd && bus.addr == `SBC_OFF_CTRL;
  endsequence
  AST_RST_QUIET: assert property ($rose(resetn) |-> rdata == 8'h00
    && !sda_oe && !irq) else $error("outputs busy after reset");
  AST_REL_LATCH: assert property (s_ctl(8'h01) |-> ##4 !sda_oe)
    else $error("release trigger left line pulled");
  AST_CMD_LATCH: assert property (s_ctl(8'h02) ##0 chen
    |-> ##4 sda_oe) else $error("command trigger did not pull line");
  AST_TRIG_RD: assert property (s_rd_ctl ##0 !$past(bus.wr)
    |=> {rdata[4], rdata[1:0]} == 3'b000)
    else $error("trigger bit read as one");
  AST_OFF_FLAGS: assert property ((!chen)[*3] ##0 s_rd_ctl
    |=> (rdata & 8'h5c) == 8'h00) else $error("flag set while off");
  AST_OFF_LINE: assert property ((!chen)[*4] |-> !sda_oe)
    else $error("line pulled while channel off");
  AST_IRQ_MASK: assert property ((mask == 8'h00)[*2] |-> !irq)
    else $error("masked interrupt raised");
  AST_OD_VALUE: assert property (sda_out == 1'b0)
    else $error("open drain value not low");
endmodule
bind sbc_ctrl sbc_checker u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .bus(bus), .rdata(rdata), .sck_in(sck_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

//--- dv/sbc_far_end.sv
// Far-side master model: serial clock and pulled-up data line
`timescale 1ns/1ps
module sbc_far_end (
  input  wire logic dut_oe, // Block pulls the data line low
  output logic      sck,    // Serial clock, idle high
  output logic      sda     // Data line level
);
  // Clock rests high outside frames, so latch moves form conditions
  initial sck = 1'b1;
  // Pull-up: the line is low only while someone pulls it
  assign sda = dut_oe ? 1'b0 : 1'b1;
  // Clock pulses of 400 ns, offset from the system clock phase
  task automatic clocks(input int n);
    #13;
    repeat (n) begin
      sck = 1'b0;
      #200 sck = 1'b1;
      #200;
    end
  endtask
endmodule

//--- dv/serial_bus_ctrl_flags_tb.sv
// Self-checking bench of the serial bus control block
`timescale 1ns/1ps
`include "sbc_params.svh"
module serial_bus_ctrl_flags_tb;
  import sbc_pkg::*;
  logic         ref_clk = 1'b0; // 20 MHz clock
  logic         resetn = 1'b0;  // Reset, active low
  sbc_bus_req_t bus = '0;       // Register request
  logic [7:0]   rdata;          // Read data
  logic         sck, sda;       // Serial pins
  logic         sda_out, sda_oe, irq;
  logic [7:0]   d;              // Last read value
  int           fail_count = 0;
  int           checks_done = 0;
  sbc_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .bus(bus),
    .rdata(rdata), .sck_in(sck), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));
  sbc_far_end far (.dut_oe(sda_oe), .sck(sck), .sda(sda));
  always #25 ref_clk = ~ref_clk;
  // Compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic t_reset;
    rd(`SBC_OFF_CTRL); chk(d, 8'h00);
    rd(16'hff70); chk(d, 8'h00);
    $display("reset test done");
  endtask
  // Latch moves with clock high make the block see its own conditions
  task automatic t_cond;
    wr(`SBC_OFF_MODE0, 8'h80);
    wr(`SBC_OFF_IRQ_MASK, 8'h03);
    wr(`SBC_OFF_CTRL, 8'h02); wt(8);
    chk({7'h0, sda_oe}, 8'h01);
    rd(`SBC_OFF_CTRL); chk(d, 8'h08);
    chk({7'h0, irq}, 8'h01);
    wr(`SBC_OFF_IRQ_STAT, 8'h02);
    wr(`SBC_OFF_IRQ_MASK, 8'h00);
    wr(`SBC_OFF_CTRL, 8'h4d); wt(8);
    chk({7'h0, sda_oe}, 8'h00);
    rd(`SBC_OFF_CTRL); chk(d, 8'h04);
    chk({7'h0, irq}, 8'h00);
    wr(`SBC_OFF_IRQ_MASK, 8'h01); wt(2);
    chk({7'h0, irq}, 8'h01);
    wr(`SBC_OFF_IRQ_STAT, 8'h01); wt(2);
    chk({7'h0, irq}, 8'h00);
    $display("condition test done");
  endtask
  // Byte of ones, then ack expected one clock past n clocks
  task automatic ack_run(input logic [7:0] post, input int n);
    wr(`SBC_OFF_XFER, 8'hff);
    far.clocks(n);
    chk({7'h0, sda_oe}, 8'h00);
    if (post != 8'h00) wr(`SBC_OFF_CTRL, post);
    far.clocks(1);
    chk({7'h0, sda_oe}, 8'h01);
    far.clocks(1);
    chk({7'h0, sda_oe}, 8'h00);
    rd(`SBC_OFF_CTRL); chk(d & 8'h0c, 8'h00);
  endtask
  task automatic t_xfer;
    wr(`SBC_OFF_XFER, 8'hff);
    rd(`SBC_OFF_CTRL); chk(d & 8'h0c, 8'h00);
    far.clocks(8);
    ack_run(8'h10, 9);
    rd(`SBC_OFF_CTRL); chk(d & 8'h10, 8'h00);
    ack_run(8'h20, 9);
    rd(`SBC_OFF_CTRL); chk(d & 8'h20, 8'h20);
    ack_run(8'h00, 8);
    $display("transfer test done");
  endtask
  task automatic t_off;
    wr(`SBC_OFF_MODE0, 8'h00); wt(4);
    rd(`SBC_OFF_CTRL); chk(d & 8'h5f, 8'h00);
    $display("disable test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_cond();
    t_xfer();
    t_off();
    stop_test();
  end
  // Whole run needs some 20 us
  initial begin
    #200us;
    fail_count++;
    stop_test();
  end
endmodule
